// ---- common/hall_fb_if.sv ----
// Link between the actuator feedback end and the control box end.
// Assumes both ends share clk; hall pins are asynchronous to the box.
`timescale 1ns/100ps
interface hall_fb_if;
  logic hall_a;
  logic hall_b;
  logic fb_power;
  logic motor_pos;
  logic motor_neg;
  logic motor_short;
  logic overload;

  modport actuator (
    output hall_a,
    output hall_b,
    output overload,
    input fb_power,
    input motor_pos,
    input motor_neg,
    input motor_short
  );

  modport box (
    input hall_a,
    input hall_b,
    input overload,
    output fb_power,
    output motor_pos,
    output motor_neg,
    output motor_short
  );
endinterface

// ---- common/hall_fb_pkg.sv ----
// Shared constants and types for the dual Hall position feedback link.
// Assumes a single 100 MHz clock on both ends and a synchronous active-low reset.
package hall_fb_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int STATE_MIN_MS = 5;
  localparam int STATE_MIN_CYC = (CLK_HZ / 1000) * STATE_MIN_MS;
  localparam int FB_LEAD_MS = 50;
  localparam int FB_LEAD_CYC = (CLK_HZ / 1000) * FB_LEAD_MS;
  localparam int STOP_QUIET_MS = 10;
  localparam int STOP_QUIET_CYC = (CLK_HZ / 1000) * STOP_QUIET_MS;

  // ----------------------------------------------------------------
  // Resolution
  // ----------------------------------------------------------------
  localparam int SHIFTS_PER_TURN = 12;
  localparam int STEP_UM_PITCH3 = 250;
  localparam int STEP_UM_PITCH4 = 333;
  localparam int POS_W = 24;

  // ----------------------------------------------------------------
  // Phase codes, order while extending: 11 -> 10 -> 00 -> 01 -> 11
  // ----------------------------------------------------------------
  localparam logic [1:0] PH_11 = 2'h3;
  localparam logic [1:0] PH_10 = 2'h2;
  localparam logic [1:0] PH_00 = 2'h0;
  localparam logic [1:0] PH_01 = 2'h1;
  localparam logic [1:0] PH_RESET = PH_11;

  typedef enum logic [1:0] {
    DIR_STOP = 2'b00,
    DIR_OUT = 2'b01,
    DIR_IN = 2'b10
  } dir_t;

  typedef enum logic [1:0] {
    CTL_IDLE = 2'b00,
    CTL_WARM = 2'b01,
    CTL_DRIVE = 2'b10,
    CTL_STOP = 2'b11
  } ctl_state_t;

endpackage

// ---- logic/hall_actuator.sv ----
// Actuator side: turns motor drive into a two-phase Gray sequence on the Hall pins.
// Assumes the box drives motor and supply pins; one step is issued per step_req.
`timescale 1ns/100ps
module hall_actuator #(
  parameter int STATE_MIN = hall_fb_pkg::STATE_MIN_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  hall_fb_if.actuator link,
  input wire logic step_req,
  input wire logic end_stop,
  output logic step_busy
);
  import hall_fb_pkg::*;

  logic [1:0] phase_reg;
  logic [31:0] dwell_reg;
  logic powered;
  logic moving_out;
  logic moving_in;

  assign powered = link.fb_power;
  assign moving_out = link.motor_pos & ~link.motor_neg & ~link.motor_short;
  assign moving_in = link.motor_neg & ~link.motor_pos & ~link.motor_short;
  assign step_busy = (dwell_reg < 32'(STATE_MIN));

  // ----------------------------------------------------------------
  // Gray sequence: one bit changes per step, 12 steps per turn
  // ----------------------------------------------------------------
  function automatic logic [1:0] next_out(input logic [1:0] p);
    case (p)
      PH_11: next_out = PH_10;
      PH_10: next_out = PH_00;
      PH_00: next_out = PH_01;
      default: next_out = PH_11;
    endcase
  endfunction

  function automatic logic [1:0] next_in(input logic [1:0] p);
    case (p)
      PH_11: next_in = PH_01;
      PH_01: next_in = PH_00;
      PH_00: next_in = PH_10;
      default: next_in = PH_11;
    endcase
  endfunction

  // Each state dwells at least STATE_MIN cycles; the high time follows the step_req spacing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase_reg <= PH_RESET;
      dwell_reg <= '0;
    end else if (powered && step_req && !step_busy && moving_out) begin
      phase_reg <= next_out(phase_reg);
      dwell_reg <= '0;
    end else if (powered && step_req && !step_busy && moving_in) begin
      phase_reg <= next_in(phase_reg);
      dwell_reg <= '0;
    end else if (step_busy) begin
      dwell_reg <= dwell_reg + 32'h1;
    end
  end

  // Hall outputs read low while unpowered
  assign link.hall_a = powered & phase_reg[1];
  assign link.hall_b = powered & phase_reg[0];
  assign link.overload = end_stop & (moving_out | moving_in);

endmodule // hall_actuator

// ---- logic/hall_box.sv ----
// Control box side: supplies feedback, drives the motor, decodes Hall phases.
// Assumes hall and overload pins are asynchronous and are synchronised here.
//
// Behaviour
// - Each phase state lasts at least 5 ms
// - Each phase keeps 30 to 70 % high (not enforced; the high time follows the step_req spacing)
// - Extending: B rises while A low
// - Retracting: A rises while B low
// - Twelve phase changes per spindle turn
// - Step scales to 0.25 or 0.3333 mm (the 4 mm pitch uses 333 um)
// - Feedback powered 50 ms before drive, through stop
// - Idle motor terminals are shorted together
// - Overload at end position removes motor current
`timescale 1ns/100ps
module hall_box #(
  parameter int FB_LEAD = hall_fb_pkg::FB_LEAD_CYC,
  parameter int STOP_QUIET = hall_fb_pkg::STOP_QUIET_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  hall_fb_if.box link,
  input wire logic cmd_out,
  input wire logic cmd_in,
  input wire logic pitch4,
  output logic signed [hall_fb_pkg::POS_W-1:0] pos_steps_reg,
  output logic signed [hall_fb_pkg::POS_W+8:0] pos_um_reg,
  output logic illegal_reg,
  output logic overload_reg,
  output logic driving
);
  import hall_fb_pkg::*;

  ctl_state_t state_reg;
  dir_t dir_reg;
  logic [31:0] timer_reg;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [1:0] last_reg;
  logic [1:0] now_ph;
  logic step_up;
  logic step_dn;
  logic step_bad;
  logic want_move;
  logic [2:0] pwr_reg;
  logic decode_en;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Overload rides the same two flops as the phases, so both lag equally
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {link.overload, link.hall_a, link.hall_b};
      sync2_reg <= sync1_reg;
    end
  end

  assign now_ph = sync2_reg[1:0];

  // ----------------------------------------------------------------
  // Power settle
  // ----------------------------------------------------------------
  // Hall pins read low while unpowered, so a supply edge looks like a step or a jump
  // of both phases; decoding waits until the synchronisers hold powered levels
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pwr_reg <= '0;
    end else begin
      pwr_reg <= {pwr_reg[1:0], link.fb_power};
    end
  end

  assign decode_en = link.fb_power && (&pwr_reg);

  // ----------------------------------------------------------------
  // Phase decode
  // ----------------------------------------------------------------
  function automatic logic [1:0] succ(input logic [1:0] p);
    case (p)
      PH_11: succ = PH_10;
      PH_10: succ = PH_00;
      PH_00: succ = PH_01;
      default: succ = PH_11;
    endcase
  endfunction

  assign step_up = (now_ph != last_reg) && (now_ph == succ(last_reg));
  assign step_dn = (now_ph != last_reg) && (last_reg == succ(now_ph));
  assign step_bad = (now_ph == ~last_reg);

  // 4 mm pitch rounds a third of a millimetre down to 333 um, so long runs drift slightly
  function automatic logic signed [POS_W+8:0] step_size(input logic p4);
    if (p4) begin
      step_size = (POS_W+9)'(STEP_UM_PITCH4);
    end else begin
      step_size = (POS_W+9)'(STEP_UM_PITCH3);
    end
  endfunction

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      last_reg <= PH_RESET;
      pos_steps_reg <= '0;
      pos_um_reg <= '0;
    end else if (!decode_en) begin
      last_reg <= now_ph;
    end else begin
      last_reg <= now_ph;
      if (step_up) begin
        pos_steps_reg <= pos_steps_reg + POS_W'(1);
        pos_um_reg <= pos_um_reg + step_size(pitch4);
      end else if (step_dn) begin
        pos_steps_reg <= pos_steps_reg - POS_W'(1);
        pos_um_reg <= pos_um_reg - step_size(pitch4);
      end
    end
  end

  // Error stays until reset; a new illegal event keeps it set
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      illegal_reg <= 1'b0;
    end else if (decode_en && step_bad) begin
      illegal_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Drive sequencing
  // ----------------------------------------------------------------
  // Both commands at once are treated as stop, never as a choice
  assign want_move = (cmd_out ^ cmd_in) && !overload_reg;

  // Latched overload keeps the motor off until both commands are released
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      overload_reg <= 1'b0;
    end else if (state_reg == CTL_DRIVE && sync2_reg[2]) begin
      overload_reg <= 1'b1;
    end else if (!cmd_out && !cmd_in) begin
      overload_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= CTL_IDLE;
      dir_reg <= DIR_STOP;
      timer_reg <= '0;
    end else begin
      case (state_reg)
        CTL_IDLE: begin
          timer_reg <= '0;
          dir_reg <= DIR_STOP;
          if (want_move) begin
            state_reg <= CTL_WARM;
          end
        end
        CTL_WARM: begin
          // Direction is taken only on leaving here; a reversal passes through stop
          if (!want_move) begin
            state_reg <= CTL_STOP;
            timer_reg <= '0;
          end else if (timer_reg >= 32'(FB_LEAD - 1)) begin
            state_reg <= CTL_DRIVE;
            dir_reg <= cmd_out ? DIR_OUT : DIR_IN;
          end else begin
            timer_reg <= timer_reg + 32'h1;
          end
        end
        CTL_DRIVE: begin
          timer_reg <= '0;
          if (!want_move || sync2_reg[2] || (cmd_out != (dir_reg == DIR_OUT))) begin
            state_reg <= CTL_STOP;
            dir_reg <= DIR_STOP;
          end
        end
        CTL_STOP: begin
          // Supply held until phases stay still for the quiet time
          if (step_up || step_dn) begin
            timer_reg <= '0;
          end else if (timer_reg >= 32'(STOP_QUIET - 1)) begin
            state_reg <= CTL_IDLE;
          end else begin
            timer_reg <= timer_reg + 32'h1;
          end
        end
        default: begin
          state_reg <= CTL_IDLE;
        end
      endcase
    end
  end

  assign driving = (state_reg == CTL_DRIVE);
  assign link.fb_power = (state_reg != CTL_IDLE);
  assign link.motor_pos = driving && (dir_reg == DIR_OUT) && !sync2_reg[2];
  assign link.motor_neg = driving && (dir_reg == DIR_IN) && !sync2_reg[2];
  // Short is the default, so a dropped command still leaves the actuator locked
  assign link.motor_short = !(link.motor_pos || link.motor_neg);

endmodule // hall_box

// ---- sim/hall_fb_assertions.sv ----
// Checker for the Hall feedback link between the two ends.
// Assumes the interface signals, one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module hall_fb_assertions #(
  parameter int STATE_MIN = 20,
  parameter int FB_LEAD = 10
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hall_a,
  input wire logic hall_b,
  input wire logic fb_power,
  input wire logic motor_pos,
  input wire logic motor_neg,
  input wire logic motor_short,
  input wire logic overload
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic drv = motor_pos | motor_neg;
  logic [1:0] last_reg;
  int dwell_reg;
  int lead_reg;
  logic pwr_q;
  // Counters stand in for long repetitions, which the tools unroll
  always_ff @(posedge clk) begin
    last_reg <= {hall_a, hall_b};
    pwr_q <= fb_power;
    // Supply edges move the pins without a real phase step, so they keep the count
    dwell_reg <= (fb_power && pwr_q && last_reg != {hall_a, hall_b}) ? 1 : dwell_reg + 1;
    lead_reg <= fb_power ? lead_reg + 1 : 0;
  end
  property p_dwell;
    fb_power && $past(fb_power) && last_reg != {hall_a, hall_b} |-> dwell_reg >= STATE_MIN;
  endproperty
  a_dwell: assert property (p_dwell) else $error("phase held too briefly");
  property p_gray;
    fb_power && $past(fb_power) |-> !(hall_a != last_reg[1] && hall_b != last_reg[0]);
  endproperty
  a_gray: assert property (p_gray) else $error("both phases changed at once");
  property p_out;
    $rose(hall_b) && $past(motor_pos) |-> !hall_a;
  endproperty
  a_out: assert property (p_out) else $error("phase b rose with a high outward");
  property p_in;
    $rose(hall_a) && $past(motor_neg) |-> !hall_b;
  endproperty
  a_in: assert property (p_in) else $error("phase a rose with b high inward");
  property p_lead;
    $rose(drv) |-> lead_reg >= FB_LEAD;
  endproperty
  a_lead: assert property (p_lead) else $error("motor driven too soon after supply");
  property p_held;
    drv |-> fb_power;
  endproperty
  a_held: assert property (p_held) else $error("supply off while driving");
  property p_short;
    motor_short == !drv && !(motor_pos && motor_neg);
  endproperty
  a_short: assert property (p_short) else $error("terminals not shorted when idle");
  property p_ovl;
    overload |-> ##[1:4] !drv;
  endproperty
  a_ovl: assert property (p_ovl) else $error("current not cut on overload");
  c_out: cover property ($rose(motor_pos));
  c_in: cover property ($rose(motor_neg));
  c_ovl: cover property ($rose(overload));
endmodule // hall_fb_assertions

// ---- sim/tb.sv ----
// Testbench joining both ends, plus a second box fed bad phases.
// Assumes shortened counts: dwell 20, lead 10, quiet 10.
`timescale 1ns/100ps
module tb;
  import hall_fb_pkg::*;
  logic clk = 0, reset_n = 0, step_req = 0, end_stop = 0, cmd_out = 0, cmd_in = 0, pitch4 = 0;
  logic step_busy, illegal_reg, overload_reg, driving, bad_ill, bad_ovr, bad_drv;
  logic [1:0] bad_cmd = 2'h0;
  logic signed [POS_W-1:0] bad_pos;
  logic signed [POS_W+8:0] bad_um;
  logic [1:0] bad_h = 2'h3;
  logic signed [POS_W-1:0] pos_steps_reg;
  logic signed [POS_W-1:0] last_pos = '0;
  logic signed [POS_W+8:0] pos_um_reg;
  logic signed [POS_W-1:0] exp_q[$];
  int miscompares = 0, n_compared = 0, cycles = 0, cnt = 0, stp = 250;
  hall_fb_if link();
  hall_fb_if bad_if();
  assign bad_if.hall_a = bad_h[1];
  assign bad_if.hall_b = bad_h[0];
  assign bad_if.overload = 1'b0;
  hall_actuator #(.STATE_MIN(20)) hall_actuator_inst (.clk, .reset_n, .link(link.actuator), .step_req,
    .end_stop, .step_busy);
  hall_box #(.FB_LEAD(10), .STOP_QUIET(10)) hall_box_inst (.clk, .reset_n, .link(link.box), .cmd_out,
    .cmd_in, .pitch4, .pos_steps_reg, .pos_um_reg, .illegal_reg, .overload_reg, .driving);
  // Long default lead keeps this box powered but never driving for the whole check
  hall_box hall_box_inst_2 (.clk, .reset_n, .link(bad_if.box), .cmd_out(bad_cmd[1]), .cmd_in(bad_cmd[0]),
    .pitch4, .pos_steps_reg(bad_pos), .pos_um_reg(bad_um), .illegal_reg(bad_ill), .overload_reg(bad_ovr),
    .driving(bad_drv));
  hall_fb_assertions #(.STATE_MIN(20), .FB_LEAD(10)) hall_fb_assertions_inst (.clk, .reset_n,
    .hall_a(link.hall_a), .hall_b(link.hall_b), .fb_power(link.fb_power), .motor_pos(link.motor_pos),
    .motor_neg(link.motor_neg), .motor_short(link.motor_short), .overload(link.overload));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      finish_test();
    end
  end
  // An unexpected count change compares against the old value and fails
  always @(negedge clk) begin
    logic signed [POS_W-1:0] e;
    if (reset_n && pos_steps_reg !== last_pos) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : last_pos;
      check("pos_steps_reg", pos_steps_reg, e);
      check("pos_um_reg", pos_um_reg, POS_W'(e) * stp);
    end
    last_pos = pos_steps_reg;
  end
  task automatic step(input int d);
    for (int i = 0; i < 100 && step_busy !== 1'b0; i++) @(negedge clk);
    step_req = 1;
    cnt += d;
    exp_q.push_back(cnt);
    @(negedge clk);
    step_req = 0;
    @(negedge clk);
  endtask
  task automatic move(input int d, input int n);
    cmd_out = (d > 0);
    cmd_in = (d < 0);
    for (int i = 0; i < 50 && driving !== 1'b1; i++) @(negedge clk);
    check("driving", driving, 1'b1);
    repeat (n) step(d);
    cmd_out = 0;
    cmd_in = 0;
    for (int i = 0; i < 100 && link.fb_power !== 1'b0; i++) @(negedge clk);
    check("motor_short", link.motor_short, 1'b1);
  endtask
  initial begin
    void'($urandom(32'hEA28));
    repeat (4) @(negedge clk);
    reset_n = 1;
    check("fb_power", link.fb_power, 1'b0);
    move(1, 12);
    move(-1, 1 + $urandom % 8);
    move(1, 1 + $urandom % 8);
    // Step while undriven must be ignored
    step_req = 1;
    repeat (3) @(negedge clk);
    step_req = 0;
    cmd_out = 1;
    cmd_in = 1;
    repeat (20) @(negedge clk);
    check("fb_power", link.fb_power, 1'b0);
    cmd_in = 0;
    for (int i = 0; i < 50 && driving !== 1'b1; i++) @(negedge clk);
    step(1);
    end_stop = 1;
    repeat (6) @(negedge clk);
    check("overload_reg", overload_reg, 1'b1);
    check("driving", driving, 1'b0);
    end_stop = 0;
    repeat (6) @(negedge clk);
    check("driving", driving, 1'b0);
    cmd_out = 0;
    repeat (30) @(negedge clk);
    check("overload_reg", overload_reg, 1'b0);
    reset_n = 0;
    pitch4 = 1;
    cnt = 0;
    stp = 333;
    repeat (4) @(negedge clk);
    reset_n = 1;
    move(1, 1 + $urandom % 12);
    move(-1, 3);
    check("illegal_reg", illegal_reg, 1'b0);
    check("queue empty", exp_q.size(), 0);
    bad_cmd = 2'h2;
    repeat (6) @(negedge clk);
    check("illegal_reg", bad_ill, 1'b0);
    check("driving", bad_drv, 1'b0);
    bad_h = 2'h0;
    repeat (6) @(negedge clk);
    check("illegal_reg", bad_ill, 1'b1);
    check("pos_steps_reg", bad_pos, 0);
    check("pos_um_reg", bad_um, 0);
    check("overload_reg", bad_ovr, 1'b0);
    finish_test();
  end
endmodule // tb
